// File: lei_defs.vh
// Constants for the loopback and error indicator block
`ifndef LEI_DEFS_VH
`define LEI_DEFS_VH

// Clock rate in hertz
`define LEI_CLK_HZ 20000000

// Hold time on a loopback button before release starts a loopback, ms
`define LEI_HOLD_MS 3000
// Hold time in clock cycles, clock kHz times hold ms, no rounding term
`define LEI_HOLD_CYC ((`LEI_CLK_HZ / 1000 * `LEI_HOLD_MS + 0) + 0)

// Minimum on time of the error indicator in unlatched mode, ms
`define LEI_ERR_HOLD_MS 1000
// Error hold time in clock cycles
`define LEI_ERR_HOLD_CYC (`LEI_CLK_HZ / 1000 * `LEI_ERR_HOLD_MS)

// Half period of the loopback indicator blink, ms
`define LEI_BLINK_MS 250
// Blink half period in clock cycles
`define LEI_BLINK_CYC (`LEI_CLK_HZ / 1000 * `LEI_BLINK_MS)

// Width of the long timers
`define LEI_TMR_W 26

// Error count at which the indicator stays lit in unlatched mode
`define LEI_ERR_SAT 7'd100
// Error counter width
`define LEI_ERR_W 7

// Register byte offsets
`define LEI_OFS_CTRL 12'h000
`define LEI_OFS_STATUS 12'h004
`define LEI_OFS_ERRCNT 12'h008

// Control register fields
`define LEI_CTRL_EXT_BIT 0
`define LEI_CTRL_RESET 32'h00000000

// Status register fields
`define LEI_ST_ACTIVE_BIT 0
`define LEI_ST_LOCAL_BIT 1
`define LEI_ST_CHAN_BIT 2
`define LEI_ST_ERRLED_BIT 3
`define LEI_ST_LOSS_BIT 4
`define LEI_ST_SAT_BIT 5
`define LEI_ST_MODE_BIT 6

// Loopback states
`define LEI_S_IDLE 2'h0
`define LEI_S_LOCAL 2'h1
`define LEI_S_REMOTE 2'h2

`endif

// File: lei_hold_timer.v
// Push button hold timer telling long holds from short presses
`default_nettype none

module lei_hold_timer #(
  parameter HOLD_CYC = 60000000,
  parameter CW = 26
) (
  input wire pclk,
  input wire presetn,
  input wire button,
  output reg long_release,
  output reg short_release
);

  // Cycles the button has been held, saturating at the hold time
  reg [CW-1:0] held;
  // Button level one cycle ago
  reg button_q;
  // Threshold at the counter width
  localparam [CW-1:0] LIMIT = HOLD_CYC[CW-1:0];

  // Count while held, classify the release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= {CW{1'b0}};
      button_q <= 1'b0;
      long_release <= 1'b0;
      short_release <= 1'b0;
    end else begin
      button_q <= button;
      long_release <= 1'b0;
      short_release <= 1'b0;
      if (button) begin
        // Held: count up to the limit
        if (held != LIMIT)
          held <= held + {{(CW-1){1'b0}}, 1'b1};
      end else begin
        held <= {CW{1'b0}};
        // Falling edge: long or short press
        if (button_q) begin
          if (held == LIMIT)
            long_release <= 1'b1;
          else
            short_release <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: lei_top.v
// Loopback control, error and data loss indicators with APB registers
`default_nettype none
`include "lei_defs.vh"

module lei_top #(
  parameter HOLD_CYC = `LEI_HOLD_CYC,
  parameter ERR_HOLD_CYC = `LEI_ERR_HOLD_CYC,
  parameter BLINK_CYC = `LEI_BLINK_CYC,
  parameter NTRIB = 4
) (
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Front panel loopback buttons: 0 higher-rate, 1 lower-rate
  input wire [1:0] loop_button,
  // Rear panel error indicator mode switch
  input wire error_indicator_mode_switch,
  // Internal test checker bit error pulse
  input wire bit_error,
  // External test signal present per lower-rate tributary
  input wire [NTRIB-1:0] ext_signal_present,
  // Link messages from the far end
  input wire remote_loop_start,
  input wire remote_loop_chan,
  input wire remote_loop_stop,
  // Link messages to the far end
  output reg link_loop_start,
  output reg link_loop_chan,
  output reg link_loop_stop,
  // Internal test signal generator and checker enable
  output reg int_test_enable,
  // Front panel indicators
  output reg [1:0] led_loop,
  output reg led_error,
  output reg led_data_loss
);

  // Timer widths, timer limits and state codes
  localparam CW = `LEI_TMR_W;
  localparam EW = `LEI_ERR_W;
  localparam [CW-1:0] ERR_HOLD = ERR_HOLD_CYC[CW-1:0];
  localparam [CW-1:0] BLINK = BLINK_CYC[CW-1:0];
  localparam [1:0] S_IDLE = `LEI_S_IDLE;
  localparam [1:0] S_LOCAL = `LEI_S_LOCAL;
  localparam [1:0] S_REMOTE = `LEI_S_REMOTE;
  // Reset value of the control word, one bit used
  localparam [31:0] CTRL_RESET = `LEI_CTRL_RESET;

  // Button classification pulses per channel
  wire [1:0] long_rel;
  wire [1:0] short_rel;
  // Loopback state and looped channel
  reg [1:0] state;
  reg [1:0] next_state;
  reg chan;
  reg next_chan;
  // Control register: external test mode select
  reg ext_mode;
  // Error count, saturating at the excess level
  reg [EW-1:0] err_cnt;
  // Latched error flag
  reg err_latched;
  // Unlatched hold timer
  reg [CW-1:0] err_hold;
  // Blink timer and phase
  reg [CW-1:0] blink_cnt;
  reg blink_on;
  // Start of a new loopback this cycle
  reg loop_begin;
  // Local request to leave loopback this cycle
  reg loop_end_local;
  // Local request to start loopback this cycle
  reg loop_start_local;

  // Decoded helpers
  // Errors count only while the internal test runs
  wire loop_active = (state != S_IDLE);
  wire unlatched = error_indicator_mode_switch;
  wire counting = int_test_enable & bit_error;
  wire saturated = (err_cnt == `LEI_ERR_SAT);

  // One hold timer per loopback button
  // A short press ends a loop, a long one can start it
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_btn
      lei_hold_timer #(
        .HOLD_CYC(HOLD_CYC),
        .CW(CW)
      ) u_hold (
        .pclk(pclk),
        .presetn(presetn),
        .button(loop_button[gi]),
        .long_release(long_rel[gi]),
        .short_release(short_rel[gi])
      );
    end
  endgenerate

  // Register address decode used by the error answer
  // Only three word offsets respond
  function is_mapped;
    input [11:0] addr;
    begin
      is_mapped = (addr == `LEI_OFS_CTRL) ||
                  (addr == `LEI_OFS_STATUS) ||
                  (addr == `LEI_OFS_ERRCNT);
    end
  endfunction

  // Loopback state decisions
  // A loop starts only from idle, so a second channel never loops
  // Remote stop wins over a local press in the same cycle
  always @* begin
    next_state = state;
    next_chan = chan;
    loop_begin = 1'b0;
    loop_end_local = 1'b0;
    loop_start_local = 1'b0;
    case (state)
      S_IDLE: begin
        // Far end asks first; it wins a same-cycle local request
        if (remote_loop_start) begin
          next_state = S_REMOTE;
          next_chan = remote_loop_chan;
          loop_begin = 1'b1;
        end else if (long_rel[0]) begin
          next_state = S_LOCAL;
          next_chan = 1'b0;
          loop_begin = 1'b1;
          loop_start_local = 1'b1;
        end else if (long_rel[1]) begin
          next_state = S_LOCAL;
          next_chan = 1'b1;
          loop_begin = 1'b1;
          loop_start_local = 1'b1;
        end
      end
      S_LOCAL, S_REMOTE: begin
        // Press on the looped channel ends the loop; the other is refused
        if (remote_loop_stop) begin
          next_state = S_IDLE;
        end else if (short_rel[chan] | long_rel[chan]) begin
          next_state = S_IDLE;
          loop_end_local = 1'b1;
        end
        // Presses on the other channel have no effect
      end
      default: begin
        next_state = S_IDLE;
        next_chan = 1'b0;
      end
    endcase
  end

  // Loopback state, link messages and test enable
  // Start and stop are one-cycle pulses; the channel bit stays put
  // Test enable follows the next state to line up with the loop
  // A remote stop sends no stop message back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      chan <= 1'b0;
      link_loop_start <= 1'b0;
      link_loop_chan <= 1'b0;
      link_loop_stop <= 1'b0;
      int_test_enable <= 1'b0;
    end else begin
      state <= next_state;
      chan <= next_chan;
      // One-cycle link messages
      link_loop_start <= loop_start_local;
      link_loop_stop <= loop_end_local;
      if (loop_start_local)
        link_loop_chan <= next_chan;
      // Internal test on higher-rate loop unless external mode
      int_test_enable <= (next_state != S_IDLE) && !next_chan && !ext_mode;
    end
  end

  // Blink timer for locally started loopback
  // Phase starts lit so the indicator shows at once
  // Timer rests outside local loops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt <= {CW{1'b0}};
      blink_on <= 1'b0;
    end else if (state != S_LOCAL) begin
      blink_cnt <= {CW{1'b0}};
      blink_on <= 1'b1;
    end else if (blink_cnt == BLINK - {{(CW-1){1'b0}}, 1'b1}) begin
      blink_cnt <= {CW{1'b0}};
      blink_on <= ~blink_on;
    end else begin
      blink_cnt <= blink_cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Loopback indicators: blink when local, steady when remote
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_loop <= 2'b00;
    end else begin
      led_loop <= 2'b00;
      if (state == S_LOCAL)
        led_loop[chan] <= blink_on;
      else if (state == S_REMOTE)
        led_loop[chan] <= 1'b1;
    end
  end

  // Error counting and latching
  // Loop start wins over an error; none can count in idle
  // Count stops at the excess level instead of wrapping
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt <= {EW{1'b0}};
      err_latched <= 1'b0;
    end else if (loop_begin) begin
      // Fresh test starts dark
      err_cnt <= {EW{1'b0}};
      err_latched <= 1'b0;
    end else if (!loop_active) begin
      // Loop off drops the latched flag
      err_latched <= 1'b0;
    end else if (counting) begin
      err_latched <= 1'b1;
      if (!saturated)
        err_cnt <= err_cnt + {{(EW-1){1'b0}}, 1'b1};
    end
  end

  // Unlatched hold timer: each error restarts a full second
  // Reloads on every counted error, so a burst keeps the light on
  // Reaches zero one full hold after the last error
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_hold <= {CW{1'b0}};
    end else if (loop_begin || !loop_active) begin
      err_hold <= {CW{1'b0}};
    end else if (counting) begin
      err_hold <= ERR_HOLD;
    end else if (err_hold != {CW{1'b0}}) begin
      err_hold <= err_hold - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Error and data loss indicators
  // External mode and idle force the error light dark
  // Data loss follows the inputs whatever the loop state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_error <= 1'b0;
      led_data_loss <= 1'b0;
    end else begin
      if (ext_mode || !loop_active || loop_begin)
        led_error <= 1'b0;
      else if (unlatched)
        led_error <= saturated || counting || (err_hold != {CW{1'b0}});
      else
        led_error <= err_latched || counting;
      // No tributary carries an external test signal
      led_data_loss <= ext_mode && !(|ext_signal_present);
    end
  end

  // APB slave: no wait states, answer in the access phase
  // Read data is taken at the setup edge and held for the access
  // Unmapped offsets answer with an error and drop writes
  // Back-to-back transfers need no idle cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ext_mode <= CTRL_RESET[`LEI_CTRL_EXT_BIT];
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        // Setup cycle: prepare the answer
        pready <= 1'b1;
        pslverr <= !is_mapped(paddr);
        prdata <= 32'h00000000;
        if (!pwrite) begin
          case (paddr)
            `LEI_OFS_CTRL: begin
              prdata[`LEI_CTRL_EXT_BIT] <= ext_mode;
            end
            `LEI_OFS_STATUS: begin
              prdata[`LEI_ST_ACTIVE_BIT] <= loop_active;
              prdata[`LEI_ST_LOCAL_BIT] <= (state == S_LOCAL);
              prdata[`LEI_ST_CHAN_BIT] <= chan;
              prdata[`LEI_ST_ERRLED_BIT] <= led_error;
              prdata[`LEI_ST_LOSS_BIT] <= led_data_loss;
              prdata[`LEI_ST_SAT_BIT] <= saturated;
              prdata[`LEI_ST_MODE_BIT] <= unlatched;
            end
            `LEI_OFS_ERRCNT: begin
              prdata[EW-1:0] <= err_cnt;
            end
            default: begin
              prdata <= 32'h00000000;
            end
          endcase
        end
      end else if (psel && penable && pready && pwrite) begin
        // Access edge: write takes effect
        if (paddr == `LEI_OFS_CTRL)
          ext_mode <= pwdata[`LEI_CTRL_EXT_BIT];
      end
    end
  end

endmodule

`default_nettype wire

// File: lei_assertions.sv
// Port checks for the loopback and error indicator block
`default_nettype none
module lei_assertions #(
  parameter NTRIB = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic error_indicator_mode_switch,
  input wire logic bit_error,
  input wire logic [NTRIB-1:0] ext_signal_present,
  input wire logic remote_loop_start,
  input wire logic remote_loop_chan,
  input wire logic remote_loop_stop,
  input wire logic link_loop_start,
  input wire logic link_loop_chan,
  input wire logic int_test_enable,
  input wire logic [1:0] led_loop,
  input wire logic led_error,
  input wire logic led_data_loss
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Far end starts channel 0 from idle
  sequence s_far_start;
    remote_loop_start && !remote_loop_chan && led_loop == 2'b00 && !int_test_enable;
  endsequence
  // Indicator lit without a gap
  sequence s_steady;
    led_loop[0] [*4];
  endsequence
  chk_far_steady: assert property (s_far_start |-> ##3 s_steady)
    else $error("far started loop not steady");
  chk_start_lights: assert property (link_loop_start && !link_loop_chan |-> ##[1:3] led_loop[0])
    else $error("loop indicator dark after start");
  chk_err_cause: assert property ($rose(led_error) |-> $past(bit_error) && $past(int_test_enable))
    else $error("error indicator lit without counted error");
  chk_unlatch_hold: assert property ($rose(led_error) && error_indicator_mode_switch |-> led_error [*8])
    else $error("unlatched error indicator too short");
  chk_latch_hold: assert property ($fell(led_error) && !error_indicator_mode_switch |-> !int_test_enable)
    else $error("latched error indicator cleared in loop");
  chk_one_chan: assert property (led_loop != 2'b11)
    else $error("two channels looped");
  chk_loss_absent: assert property (led_data_loss |-> $past(ext_signal_present) == {NTRIB{1'b0}})
    else $error("data loss with signal present");
  chk_far_stop: assert property (remote_loop_stop && int_test_enable |-> ##[1:3] !int_test_enable)
    else $error("far stop did not end loop");
  chk_test_chan: assert property (int_test_enable |-> !led_loop[1])
    else $error("internal test on lower-rate loop");
endmodule
`default_nettype wire

// File: lei_far_end.sv
// Far-end radio model answering loopback messages over the link
`default_nettype none
module lei_far_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_loop_start,
  input wire logic link_loop_stop,
  input wire logic cmd_start,
  input wire logic cmd_chan,
  input wire logic cmd_stop,
  output logic remote_loop_start,
  output logic remote_loop_chan,
  output logic remote_loop_stop,
  output logic looped
);
  timeunit 1ns;
  timeprecision 1ns;
  // Loop state and link pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      looped <= 1'b0;
      remote_loop_start <= 1'b0;
      remote_loop_chan <= 1'b0;
      remote_loop_stop <= 1'b0;
    end else begin
      remote_loop_start <= cmd_start;
      remote_loop_stop <= cmd_stop;
      if (cmd_start) begin
        remote_loop_chan <= cmd_chan;
      end
      // Loops on request, leaves on either stop
      if (link_loop_start || cmd_start) begin
        looped <= 1'b1;
      end else if (link_loop_stop || cmd_stop) begin
        looped <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: test_loopback_error_indicator.sv
// Self-checking bench for the loopback and error indicator block
`default_nettype none
`include "lei_defs.vh"
module test_loopback_error_indicator;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 20;
  localparam int EH = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bit_error, mode_sw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0] loop_button, led_loop;
  logic [3:0] ext_in;
  logic r_start, r_chan, r_stop, l_start, l_chan, l_stop, int_en, led_error, led_loss, rerr;
  logic cmd_start, cmd_chan, cmd_stop, far_looped;
  int errors, checked;
  lei_top #(.HOLD_CYC(HOLD), .ERR_HOLD_CYC(EH), .BLINK_CYC(4), .NTRIB(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .loop_button(loop_button), .error_indicator_mode_switch(mode_sw), .bit_error(bit_error),
    .ext_signal_present(ext_in), .remote_loop_start(r_start), .remote_loop_chan(r_chan),
    .remote_loop_stop(r_stop), .link_loop_start(l_start), .link_loop_chan(l_chan),
    .link_loop_stop(l_stop), .int_test_enable(int_en), .led_loop(led_loop),
    .led_error(led_error), .led_data_loss(led_loss));
  lei_far_end u_far (.pclk(pclk), .presetn(presetn), .link_loop_start(l_start),
    .link_loop_stop(l_stop), .cmd_start(cmd_start), .cmd_chan(cmd_chan), .cmd_stop(cmd_stop),
    .remote_loop_start(r_start), .remote_loop_chan(r_chan), .remote_loop_stop(r_stop),
    .looped(far_looped));
  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic test_done;
    $display("Checked %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // APB transfer, result in rdat and rerr
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        test_done;
      end
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic press(input int ch, input int n);
    loop_button[ch] <= 1'b1;
    tick(n);
    loop_button[ch] <= 1'b0;
  endtask
  // Long press, then wait for the start message
  task automatic start0;
    int n;
    n = 0;
    press(0, HOLD + 4);
    while (l_start !== 1'b1) begin
      n++;
      if (n > 40) begin
        errors++;
        test_done;
      end
      @(posedge pclk);
    end
  endtask
  task automatic err(input int n);
    bit_error <= 1'b1;
    tick(n);
    bit_error <= 1'b0;
  endtask
  // Changes of the channel 0 indicator over four blink half periods
  task automatic edges(output int e);
    logic p;
    e = 0;
    p = led_loop[0];
    repeat (16) begin
      @(posedge pclk);
      if (led_loop[0] !== p) e++;
      p = led_loop[0];
    end
  endtask
  task automatic t_regs;
    apb(1'b0, `LEI_OFS_CTRL, 32'h0);
    chk(rdat, `LEI_CTRL_RESET);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rerr, 1);
    mode_sw <= 1'b1;
    tick(3);
    apb(1'b0, `LEI_OFS_STATUS, 32'h0);
    chk(rdat[`LEI_ST_MODE_BIT], 1);
    mode_sw <= 1'b0;
    $display("t_regs done");
  endtask
  task automatic t_latched;
    int e;
    press(0, 2);
    tick(6);
    chk(led_loop, 0);
    start0;
    chk(l_chan, 0);
    tick(4);
    chk(far_looped, 1);
    chk(int_en, 1);
    chk(led_error, 0);
    edges(e);
    chk(e > 2, 1);
    err(1);
    tick(2);
    chk(led_error, 1);
    tick(20);
    chk(led_error, 1);
    press(0, 2);
    tick(3);
    chk(l_stop, 1);
    tick(3);
    chk(far_looped, 0);
    chk(led_error, 0);
    $display("t_latched done");
  endtask
  task automatic t_unlatch;
    mode_sw <= 1'b1;
    start0;
    tick(4);
    apb(1'b0, `LEI_OFS_ERRCNT, 32'h0);
    chk(rdat, 0);
    err(1);
    tick(EH - 3);
    chk(led_error, 1);
    tick(8);
    chk(led_error, 0);
    err(99);
    tick(EH + 10);
    chk(led_error, 1);
    apb(1'b0, `LEI_OFS_STATUS, 32'h0);
    chk(rdat[`LEI_ST_SAT_BIT], 1);
    press(0, 2);
    tick(6);
    chk(led_error, 0);
    mode_sw <= 1'b0;
    $display("t_unlatch done");
  endtask
  task automatic t_remote;
    int e;
    cmd_chan <= 1'b0;
    cmd_start <= 1'b1;
    tick(1);
    cmd_start <= 1'b0;
    tick(4);
    edges(e);
    chk(e, 0);
    chk(led_loop[0], 1);
    press(1, HOLD + 4);
    tick(6);
    chk(led_loop[1], 0);
    cmd_stop <= 1'b1;
    tick(1);
    cmd_stop <= 1'b0;
    tick(4);
    chk(led_loop, 0);
    $display("t_remote done");
  endtask
  task automatic t_ext;
    apb(1'b1, `LEI_OFS_CTRL, 32'h1);
    ext_in <= 4'h0;
    tick(3);
    chk(led_loss, 1);
    ext_in <= 4'h4;
    tick(3);
    chk(led_loss, 0);
    start0;
    tick(3);
    chk(int_en, 0);
    err(1);
    tick(3);
    chk(led_error, 0);
    press(0, 2);
    tick(4);
    $display("t_ext done");
  endtask
  // Local loop on the lower-rate channel, ended by the far end
  task automatic t_low;
    int n;
    n = 0;
    press(1, HOLD + 4);
    while (l_start !== 1'b1) begin
      n++;
      if (n > 40) begin
        errors++;
        test_done;
      end
      @(posedge pclk);
    end
    chk(l_chan, 1);
    tick(1);
    chk(led_loop, 2'b10);
    chk(int_en, 0);
    err(1);
    tick(3);
    chk(led_error, 0);
    press(0, HOLD + 4);
    tick(6);
    chk(led_loop[0], 0);
    cmd_stop <= 1'b1;
    tick(1);
    cmd_stop <= 1'b0;
    tick(2);
    chk(l_stop, 0);
    tick(2);
    chk(led_loop, 0);
    chk(far_looped, 0);
    $display("t_low done");
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, bit_error, mode_sw, cmd_start, cmd_chan, cmd_stop} = '0;
    paddr = '0;
    pwdata = '0;
    loop_button = '0;
    ext_in = 4'hF;
    errors = 0;
    checked = 0;
    tick(3);
    presetn <= 1'b1;
    t_regs;
    t_latched;
    t_unlatch;
    t_remote;
    t_low;
    t_ext;
    test_done;
  end
endmodule
bind lei_top lei_assertions #(.NTRIB(NTRIB)) u_chk (.pclk(pclk), .presetn(presetn),
  .error_indicator_mode_switch(error_indicator_mode_switch), .bit_error(bit_error),
  .ext_signal_present(ext_signal_present), .remote_loop_start(remote_loop_start),
  .remote_loop_chan(remote_loop_chan), .remote_loop_stop(remote_loop_stop),
  .link_loop_start(link_loop_start), .link_loop_chan(link_loop_chan),
  .int_test_enable(int_test_enable), .led_loop(led_loop), .led_error(led_error),
  .led_data_loss(led_data_loss));
`default_nettype wire
